/* File: logic/tmc_cfg.svh */
// Constants for the timer/counter with shared prescaler
// Overview of operation
// - Source select clear: count instruction cycles, once per cycle when the prescaler is assigned to watchdog.
// - After a counter write, block increments for the next two cycles.
// - Source select set: count on transitions of the external input.
// - Edge select clear picks rising edge, set picks falling edge.
// - Prescaler serves counter or watchdog only; an unassigned counter runs unscaled, an unassigned watchdog never pulses.
// - Assignment clear gives prescaler to counter, set gives it to watchdog.
// - Counter-side ratio selectable from 1:2 up to 1:256 in powers of two.
// - Prescaler is an 8-bit counter, not readable or writable by software.
// - Assigned to watchdog, prescaler divides watchdog time-out as postscaler.
// - Assigned to counter, every counter write clears the prescaler.
// - Assigned to watchdog, watchdog clear also clears the prescaler.
// - Reset leaves the prescaler all zeros.
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH

`define TMC_OPT_RATIO_LSB   0
`define TMC_OPT_ASSIGN_BIT  3
`define TMC_OPT_EDGE_BIT    4
`define TMC_OPT_SOURCE_BIT  5
`define TMC_OPT_RESET       6'h3F
`define TMC_COUNT_RESET     8'h00
`define TMC_SCALE_RESET     8'h00
`define TMC_INHIBIT_CYCLES  2'h2

`endif

/* File: logic/tmc_pkg.sv */
// Types for the timer/counter with shared prescaler
package tmc_pkg;
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] scale;
    logic [1:0] inhibit;
    logic       ext_prev;
    logic       scale_tap_prev;
    logic       wdt_pulse;
    logic [7:0] rd_data;
  } tmc_state_t;
endpackage

/* File: logic/tmc_edge_detect.sv */
// Edge detector for the external count input
`timescale 1ns/1ps
module tmc_edge_detect (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic sig_in,
  input  wire logic falling_sel,
  output logic      edge_pulse
);
  logic prev_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Track the pin through reset so a high idle level gives no false edge
      prev_reg   <= sig_in;
      edge_pulse <= 1'b0;
    end else begin
      prev_reg   <= sig_in;
      edge_pulse <= falling_sel ? (prev_reg & ~sig_in) : (~prev_reg & sig_in);
    end
  end
endmodule

/* File: logic/tmc_timer.sv */
// Timer/counter with 8-bit prescaler shared with the watchdog
`timescale 1ns/1ps
`include "tmc_cfg.svh"
module tmc_timer (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       instr_cycle_en,
  input  wire logic       count_write,
  input  wire logic [7:0] count_wdata,
  input  wire logic       watchdog_clear_op,
  input  wire logic       watchdog_tick,
  input  wire logic       external_count_input,
  input  wire logic       count_source_select,
  input  wire logic       external_edge_select,
  input  wire logic       scaler_assignment,
  input  wire logic [2:0] scaler_ratio_field,
  output logic [7:0]      timer_count,
  output logic            watchdog_timeout_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tmc_pkg::tmc_state_t state_reg;
  tmc_pkg::tmc_state_t state_next;
  logic                ext_edge;

  tmc_edge_detect u_edge (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .sig_in      (external_count_input),
    .falling_sel (external_edge_select),
    .edge_pulse  (ext_edge)
  );

  // Prescaler output bit for a given ratio field
  function automatic logic scale_tap(input logic [7:0] sc, input logic [2:0] ratio);
    scale_tap = sc[ratio];
  endfunction

  logic source_tick;
  logic pre_clock;
  logic counter_owns;
  logic tap_now;
  logic inc;

  always_comb begin
    state_next   = state_reg;
    counter_owns = ~scaler_assignment;
    source_tick  = count_source_select ? ext_edge : instr_cycle_en;
    pre_clock    = counter_owns ? source_tick : watchdog_tick;
    inc          = 1'b0;
    tap_now      = 1'b0;
    state_next.wdt_pulse = 1'b0;
    if (pre_clock) begin
      state_next.scale = state_reg.scale + 8'h01;
    end
    tap_now = scale_tap(state_next.scale, scaler_ratio_field);
    // Counter advances on the falling of the selected tap, so ratio is 2^(n+1)
    if (counter_owns) begin
      inc = pre_clock & state_reg.scale_tap_prev & ~tap_now;
    end else begin
      inc = source_tick;
      state_next.wdt_pulse = pre_clock & state_reg.scale_tap_prev & ~tap_now;
    end
    state_next.scale_tap_prev = tap_now;
    if (instr_cycle_en && state_reg.inhibit != 2'h0) begin
      state_next.inhibit = state_reg.inhibit - 2'h1;
    end
    if (inc && state_reg.inhibit == 2'h0) begin
      state_next.count = state_reg.count + 8'h01;
    end
    if (count_write) begin
      state_next.count   = count_wdata;
      state_next.inhibit = `TMC_INHIBIT_CYCLES;
      if (counter_owns) begin
        state_next.scale          = `TMC_SCALE_RESET;
        state_next.scale_tap_prev = 1'b0;
      end
    end
    if (watchdog_clear_op && !counter_owns) begin
      state_next.scale          = `TMC_SCALE_RESET;
      state_next.scale_tap_prev = 1'b0;
    end
    state_next.rd_data = state_next.count;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg       <= '0;
      state_reg.count <= `TMC_COUNT_RESET;
      state_reg.scale <= `TMC_SCALE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign timer_count            = state_reg.rd_data;
  assign watchdog_timeout_pulse = state_reg.wdt_pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_scale;
    @(posedge sys_clk) !rst_n |=> state_reg.scale == 8'h00;
  endproperty
  a_reset_scale: assert property (p_reset_scale) else $error("prescaler not zero");

  property p_write_loads;
    @(posedge sys_clk) disable iff (!rst_n) count_write |=> timer_count == $past(count_wdata);
  endproperty
  a_write_loads: assert property (p_write_loads) else $error("write not loaded");

  sequence s_write_quiet;
    count_write ##1 (!count_write && instr_cycle_en);
  endsequence
  property p_inhibit;
    @(posedge sys_clk) disable iff (!rst_n) s_write_quiet |=> $stable(timer_count);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("count moved in hold");

  property p_write_clears;
    @(posedge sys_clk) disable iff (!rst_n)
      (count_write && !scaler_assignment) |=> state_reg.scale == 8'h00;
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("prescaler kept");

  property p_wdt_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (watchdog_clear_op && scaler_assignment) |=> state_reg.scale == 8'h00;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("wdt clear missed");

  property p_timer_unscaled;
    @(posedge sys_clk) disable iff (!rst_n)
      (scaler_assignment && !count_source_select && instr_cycle_en && !count_write
       && state_reg.inhibit == 2'h0) |=> timer_count == $past(timer_count) + 8'h01;
  endproperty
  a_timer_unscaled: assert property (p_timer_unscaled) else $error("no tick");

  property p_counter_ext;
    @(posedge sys_clk) disable iff (!rst_n)
      (scaler_assignment && count_source_select && !ext_edge && !count_write)
      |=> $stable(timer_count);
  endproperty
  a_counter_ext: assert property (p_counter_ext) else $error("count w/o edge");

  property p_no_wdt_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      !scaler_assignment |=> !watchdog_timeout_pulse;
  endproperty
  a_no_wdt_pulse: assert property (p_no_wdt_pulse) else $error("wdt scaled");

  // ----------------------------------------------------------------
  // Checks: reset
  // ----------------------------------------------------------------
  property p_reset_count;
    @(posedge sys_clk) !rst_n |=> timer_count == `TMC_COUNT_RESET;
  endproperty
  a_reset_count: assert property (p_reset_count) else $error("count not cleared");

  property p_reset_pulse;
    @(posedge sys_clk) !rst_n |=> !watchdog_timeout_pulse;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("pulse after reset");

  property p_reset_inhibit;
    @(posedge sys_clk) !rst_n |=> state_reg.inhibit == 2'h0;
  endproperty
  a_reset_inhibit: assert property (p_reset_inhibit) else $error("hold after reset");

  // ----------------------------------------------------------------
  // Checks: counter writes
  // ----------------------------------------------------------------
  property p_write_arms;
    @(posedge sys_clk) disable iff (!rst_n) count_write |=> state_reg.inhibit == 2'h2;
  endproperty
  a_write_arms: assert property (p_write_arms) else $error("hold not armed");

  // Any pending hold freezes the count, whatever the source
  property p_inhibit_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg.inhibit != 2'h0 && !count_write) |=> $stable(timer_count);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved in hold");

  property p_inhibit_drain;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_reg.inhibit != 2'h0 && instr_cycle_en && !count_write)
      |=> state_reg.inhibit == $past(state_reg.inhibit) - 2'h1;
  endproperty
  a_inhibit_drain: assert property (p_inhibit_drain) else $error("hold not drained");

  property p_write_keeps_wdt;
    @(posedge sys_clk) disable iff (!rst_n)
      (count_write && scaler_assignment && !watchdog_clear_op && !watchdog_tick)
      |=> $stable(state_reg.scale);
  endproperty
  a_write_keeps_wdt: assert property (p_write_keeps_wdt) else $error("wdt scaler hit");

  // ----------------------------------------------------------------
  // Checks: timer and counter mode
  // ----------------------------------------------------------------
  property p_timer_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (!count_source_select && !instr_cycle_en && !count_write)
      |=> $stable(timer_count);
  endproperty
  a_timer_idle: assert property (p_timer_idle) else $error("count w/o cycle");

  property p_counter_ext_inc;
    @(posedge sys_clk) disable iff (!rst_n)
      (scaler_assignment && count_source_select && ext_edge && !count_write
       && state_reg.inhibit == 2'h0) |=> timer_count == $past(timer_count) + 8'h01;
  endproperty
  a_counter_ext_inc: assert property (p_counter_ext_inc) else $error("edge lost");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (scaler_assignment && !count_source_select && instr_cycle_en && !count_write
       && state_reg.inhibit == 2'h0 && timer_count == 8'hFF) |=> timer_count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  // ----------------------------------------------------------------
  // Checks: edge select
  // ----------------------------------------------------------------
  sequence s_pin_rise;
    !external_count_input ##1 external_count_input;
  endsequence
  sequence s_pin_fall;
    external_count_input ##1 !external_count_input;
  endsequence

  property p_rise_seen;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_pin_rise ##0 !external_edge_select) |=> ext_edge;
  endproperty
  a_rise_seen: assert property (p_rise_seen) else $error("rise missed");

  property p_fall_seen;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_pin_fall ##0 external_edge_select) |=> ext_edge;
  endproperty
  a_fall_seen: assert property (p_fall_seen) else $error("fall missed");

  property p_rise_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_pin_rise ##0 external_edge_select) |=> !ext_edge;
  endproperty
  a_rise_ignored: assert property (p_rise_ignored) else $error("rise taken");

  property p_fall_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_pin_fall ##0 !external_edge_select) |=> !ext_edge;
  endproperty
  a_fall_ignored: assert property (p_fall_ignored) else $error("fall taken");

  property p_level_quiet;
    @(posedge sys_clk) disable iff (!rst_n) $stable(external_count_input) |=> !ext_edge;
  endproperty
  a_level_quiet: assert property (p_level_quiet) else $error("edge w/o pin move");

  // ----------------------------------------------------------------
  // Checks: prescaler
  // ----------------------------------------------------------------
  property p_scale_step;
    @(posedge sys_clk) disable iff (!rst_n)
      (!scaler_assignment && !count_source_select && instr_cycle_en && !count_write)
      |=> state_reg.scale == $past(state_reg.scale) + 8'h01;
  endproperty
  a_scale_step: assert property (p_scale_step) else $error("scaler not stepped");

  property p_scale_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (!scaler_assignment && !count_source_select && !instr_cycle_en && !count_write)
      |=> $stable(state_reg.scale);
  endproperty
  a_scale_hold: assert property (p_scale_hold) else $error("scaler drifted");

  property p_wdt_scale_step;
    @(posedge sys_clk) disable iff (!rst_n)
      (scaler_assignment && watchdog_tick && !watchdog_clear_op)
      |=> state_reg.scale == $past(state_reg.scale) + 8'h01;
  endproperty
  a_wdt_scale_step: assert property (p_wdt_scale_step) else $error("wdt tick lost");

  // ----------------------------------------------------------------
  // Checks: watchdog output
  // ----------------------------------------------------------------
  property p_pulse_needs_tick;
    @(posedge sys_clk) disable iff (!rst_n)
      (scaler_assignment && !watchdog_tick) |=> !watchdog_timeout_pulse;
  endproperty
  a_pulse_needs_tick: assert property (p_pulse_needs_tick) else $error("pulse w/o tick");

  property p_pulse_single;
    @(posedge sys_clk) disable iff (!rst_n)
      watchdog_timeout_pulse |=> !watchdog_timeout_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("pulse too long");

  // First tick may carry a tap from an older ratio, so three are needed
  sequence s_three_ticks;
    (scaler_assignment && watchdog_tick && scaler_ratio_field == 3'h0
     && !watchdog_clear_op) [*3];
  endsequence
  property p_ratio_zero_rate;
    @(posedge sys_clk) disable iff (!rst_n)
      s_three_ticks |=> (watchdog_timeout_pulse || $past(watchdog_timeout_pulse));
  endproperty
  a_ratio_zero_rate: assert property (p_ratio_zero_rate) else $error("wdt rate");
endmodule

/* File: tb/tmc_pin_model.sv */
// Behavioural source driving the external count pin
`timescale 1ns/1ps
module tmc_pin_model (
  input  wire logic sys_clk,
  input  wire logic req_level,
  input  wire logic slow,
  output logic      pin
);
  logic [1:0] wait_reg = 2'h0;
  initial pin = 1'b0;
  // Slow mode lags each request by a few cycles, like a sluggish source
  always @(posedge sys_clk) begin
    if (req_level == pin) begin
      wait_reg <= 2'h0;
    end else if (!slow || wait_reg == 2'h3) begin
      pin <= req_level;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

/* File: tb/main_counter_module_with_shared_prescaler_tb.sv */
// Self-checking bench for the timer/counter with shared prescaler
`timescale 1ns/1ps
module main_counter_module_with_shared_prescaler_tb;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       en      = 1'b0;
  logic       wr_s    = 1'b0;
  logic [7:0] wdata   = 8'h00;
  logic       clr     = 1'b0;
  logic       wtick   = 1'b0;
  logic       pin_req = 1'b0;
  logic       slow    = 1'b0;
  logic       src     = 1'b0;
  logic       edg     = 1'b0;
  logic       asg     = 1'b0;
  logic [2:0] ratio   = 3'h0;
  logic       pin;
  logic [7:0] count;
  logic [7:0] base;
  logic       wdt_out;
  int         wdt_seen = 0;
  int         w0;
  int         fail_count = 0;
  int         n_tests    = 0;
  always #12.5 sys_clk = ~sys_clk;
  tmc_pin_model ext (.sys_clk(sys_clk), .req_level(pin_req), .slow(slow), .pin(pin));
  tmc_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_cycle_en(en), .count_write(wr_s),
    .count_wdata(wdata), .watchdog_clear_op(clr), .watchdog_tick(wtick),
    .external_count_input(pin), .count_source_select(src), .external_edge_select(edg),
    .scaler_assignment(asg), .scaler_ratio_field(ratio), .timer_count(count),
    .watchdog_timeout_pulse(wdt_out));
  always @(posedge sys_clk) if (wdt_out === 1'b1) wdt_seen <= wdt_seen + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Extra idle cycle at the end is slack; the last increment already lands on the final enabled edge
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk) en = 1'b1;
    @(negedge sys_clk) en = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] v);
    @(negedge sys_clk) wr_s = 1'b1;
    wdata = v;
    @(negedge sys_clk) wr_s = 1'b0;
  endtask
  task automatic pin_to(input logic v);
    @(negedge sys_clk) pin_req = v;
    repeat (10) @(negedge sys_clk);
  endtask
  // Option change always follows the safe software order
  task automatic opt(input logic s, input logic e, input logic a, input logic [2:0] r);
    @(negedge sys_clk) clr = 1'b1;
    @(negedge sys_clk) clr = 1'b0;
    wr(8'h00);
    @(negedge sys_clk) src = s;
    edg = e;
    asg = a;
    ratio = r;
  endtask
  initial begin
    #500000;
    fail_count++;
    end_sim;
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    tick(1);
    chk(count, 8'h00);
    tick(1);
    chk(count, 8'h01);
    opt(1'b0, 1'b0, 1'b1, 3'h0);
    wr(8'hFE);
    chk(count, 8'hFE);
    tick(2);
    chk(count, 8'hFE);
    tick(1);
    chk(count, 8'hFF);
    tick(1);
    chk(count, 8'h00);
    // Three prescaler periods give three increments whatever the phase
    for (int n = 0; n < 8; n++) begin
      opt(1'b0, 1'b0, 1'b0, n[2:0]);
      tick(4);
      base = count;
      tick(3 << (n + 1));
      chk(count, base + 8'h03);
    end
    // Watchdog ticks run meanwhile and must not reach the counter
    wtick = 1'b1;
    for (int e = 0; e < 2; e++) begin
      opt(1'b1, e[0], 1'b1, 3'h0);
      tick(2);
      slow = e[0];
      repeat (3) begin
        pin_to(1'b1);
        pin_to(1'b0);
      end
      chk(count, 8'h03);
      pin_to(1'b1);
      chk(count, e[0] ? 8'h03 : 8'h04);
      pin_to(1'b0);
      chk(count, 8'h04);
    end
    // Watchdog owns the scaler: one timeout per 2^(r+1) ticks
    for (int r = 0; r < 3; r += 2) begin
      opt(1'b0, 1'b0, 1'b1, r[2:0]);
      repeat (2) @(negedge sys_clk);
      w0 = wdt_seen;
      repeat (8 << r) @(negedge sys_clk);
      chk(8'(wdt_seen - w0), 8'h04);
    end
    end_sim;
  end
endmodule
